/* fis_pkg.sv */
// Shared constants and types for the FIFO level flag interrupt status block.
// Assumes a 32-bit APB register bus with byte addresses and one clock domain.
package fis_pkg;

  // Byte offsets of the registers on the bus.
  localparam logic [7:0] OFS_ENABLE = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;

  // Number of flags kept here and the register bit of the first one.
  localparam int FLAG_COUNT = 6;
  localparam int FLAG_LSB   = 8;

  // Index of each flag inside the local vector; register bit is FLAG_LSB plus index.
  localparam int IDX_TX_EMPTY   = 0;
  localparam int IDX_TX_AEMPTY  = 1;
  localparam int IDX_TX_AFULL   = 2;
  localparam int IDX_TX_FULL    = 3;
  localparam int IDX_RX_EMPTY   = 4;
  localparam int IDX_RX_AEMPTY  = 5;

  // Values after reset.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [5:0]  RST_FLAG = 6'h00;

  // Live FIFO level conditions, packed in the same order as the register bits.
  typedef struct packed {
    logic rx_aempty;
    logic rx_empty;
    logic tx_full;
    logic tx_afull;
    logic tx_aempty;
    logic tx_empty;
  } fis_flags_t;

endpackage

/* fis_flag_cell.sv */
// One dual-purpose status bit: a sticky event latch or a live condition mirror.
// Assumes the condition comes from logic on the same clock and the clear is a one-cycle pulse.
`timescale 1ns/1ps
module fis_flag_cell
  import fis_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic enable_i,
  input  wire logic cond_i,
  input  wire logic clear_i,
  output logic      latched_o,
  output logic      view_o
);

  // The latch only captures while enabled; a capture in the clear cycle wins so no event is lost.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latched_o <= 1'b0;
    end else if (ce_i) begin
      if (enable_i && cond_i) begin
        latched_o <= 1'b1;
      end else if (clear_i) begin
        latched_o <= 1'b0;
      end
    end
  end

  // Enabled bits show the latch, disabled bits show the condition as it stands now.
  assign view_o = enable_i ? latched_o : cond_i;

endmodule

/* fis_irq_status.sv */
// Interrupt enable and status registers for the transmit and receive FIFO level flags.
// Assumes an APB master on CLK_I and FIFO flags produced by logic on the same clock.
// Notes on behaviour
// - The transmit-empty bit latches its event while enabled and shows the live empty level while disabled.
// - Bit 9 reports transmit-almost-empty, latched while enabled and live while disabled.
// - Bit 10 reports transmit-almost-full, latched while enabled and live while disabled.
// - The transmit-full bit reads one once a full event was caught while enabled, and shows the live full level while disabled.
// - Bit 12 reports receive-empty, latched while enabled and live while disabled.
// - The receive-almost-empty bit latches while enabled and otherwise shows the live almost-empty level.
// - A latched bit stays set until software clears that one bit, and every bit works on its own.
// - Each bit's latched or live behaviour is chosen by the matching bit of the enable register.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module fis_irq_status
  import fis_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire fis_flags_t  FIFO_FLAGS_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             IRQ_O
);

  logic [FLAG_COUNT-1:0] enable;
  logic [FLAG_COUNT-1:0] latched;
  logic [FLAG_COUNT-1:0] view;
  logic [FLAG_COUNT-1:0] cond;
  logic [FLAG_COUNT-1:0] clear;
  logic                  setup;
  logic                  done;
  logic                  hit_enable;
  logic                  hit_status;
  logic                  answer;
  logic [31:0]           next_rdata;

  // Bus phase decode; a request completes on the edge where the registered ready is seen high.
  assign setup      = PSEL_I && !PENABLE_I;
  assign done       = PSEL_I && PENABLE_I && PREADY_O;
  assign hit_enable = (PADDR_I == OFS_ENABLE);
  assign hit_status = (PADDR_I == OFS_STATUS);
  assign answer     = PSEL_I && !PREADY_O;
  assign cond       = FIFO_FLAGS_I;

  // Write-one-to-clear pulses for the status bits, only at the completing edge.
  assign clear = (done && PWRITE_I && hit_status) ? PWDATA_I[FLAG_LSB +: FLAG_COUNT] : RST_FLAG;

  // The enable register picks latched or live behaviour per bit and doubles as the interrupt mask.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      enable <= RST_FLAG;
    end else if (CE_I && done && PWRITE_I && hit_enable) begin
      enable <= PWDATA_I[FLAG_LSB +: FLAG_COUNT];
    end
  end

  // One status cell per flag; each keeps its own latch so bits never disturb each other.
  for (genvar g = 0; g < FLAG_COUNT; g++) begin : g_cell
    fis_flag_cell u_cell (
      .clk_i     (CLK_I),
      .rst_n_i   (RST_N_I),
      .ce_i      (CE_I),
      .enable_i  (enable[g]),
      .cond_i    (cond[g]),
      .clear_i   (clear[g]),
      .latched_o (latched[g]),
      .view_o    (view[g])
    );
  end

  // Read data is chosen in the setup cycle so that the data output can come straight from a flop.
  always_comb begin
    next_rdata = RST_WORD;
    if (hit_enable) begin
      next_rdata[FLAG_LSB +: FLAG_COUNT] = enable;
    end else if (hit_status) begin
      next_rdata[FLAG_LSB +: FLAG_COUNT] = view;
    end
  end

  // Ready rises one edge after the select is seen, so an access has no wait state while CE_I stays high.
  // Keying on the select rather than on the setup cycle alone keeps a request alive through a frozen setup edge.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= RST_WORD;
    end else if (CE_I) begin
      PREADY_O  <= answer;
      PSLVERR_O <= answer && !hit_enable && !hit_status;
      if (answer && !PWRITE_I) begin
        PRDATA_O <= next_rdata;
      end
    end
  end

  // Level interrupt; latches of disabled bits are held back even if they were caught earlier.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else if (CE_I) begin
      IRQ_O <= |(latched & enable);
    end
  end

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_read_status;
    CE_I && setup && !PWRITE_I && hit_status;
  endsequence

  sequence s_clear_bit(int i);
    CE_I && clear[i] && !(enable[i] && cond[i]);
  endsequence

  a_txe_event_latch: assert property (
    CE_I && enable[IDX_TX_EMPTY] && cond[IDX_TX_EMPTY] |=> latched[IDX_TX_EMPTY])
    else $error("transmit empty event was not latched");

  a_txae_live_read: assert property (
    s_read_status ##0 !enable[IDX_TX_AEMPTY]
      |=> PRDATA_O[FLAG_LSB + IDX_TX_AEMPTY] == $past(cond[IDX_TX_AEMPTY]))
    else $error("disabled almost-empty bit did not read the live level");

  a_txaf_latch_read: assert property (
    s_read_status ##0 enable[IDX_TX_AFULL]
      |=> PRDATA_O[FLAG_LSB + IDX_TX_AFULL] == $past(latched[IDX_TX_AFULL]))
    else $error("enabled almost-full bit did not read its latch");

  a_txf_zero_idle: assert property (
    s_read_status ##0 (enable[IDX_TX_FULL] && !latched[IDX_TX_FULL]) |=> !PRDATA_O[FLAG_LSB + IDX_TX_FULL])
    else $error("transmit full bit read one without a captured event");

  a_rxe_event_read: assert property (
    CE_I && enable[IDX_RX_EMPTY] && cond[IDX_RX_EMPTY] ##1 s_read_status ##0 enable[IDX_RX_EMPTY]
      |=> PRDATA_O[FLAG_LSB + IDX_RX_EMPTY])
    else $error("receive empty event did not show on read");

  a_rxae_no_spurious: assert property (
    CE_I && !latched[IDX_RX_AEMPTY] && !(enable[IDX_RX_AEMPTY] && cond[IDX_RX_AEMPTY])
      |=> !latched[IDX_RX_AEMPTY])
    else $error("receive almost-empty latch set without an enabled event");

  a_latch_sticky_hold: assert property (
    latched[IDX_TX_AEMPTY] && !clear[IDX_TX_AEMPTY] |=> latched[IDX_TX_AEMPTY])
    else $error("latched bit dropped without a clear");

  a_latch_clear_one: assert property (
    s_clear_bit(IDX_TX_FULL) ##0 !clear[IDX_RX_EMPTY] ##0 latched[IDX_RX_EMPTY]
      |=> !latched[IDX_TX_FULL] && latched[IDX_RX_EMPTY])
    else $error("clear did not act on its own bit alone");

  a_enable_write_takes: assert property (
    CE_I && done && PWRITE_I && hit_enable
      |=> enable == $past(PWDATA_I[FLAG_LSB +: FLAG_COUNT]))
    else $error("enable register did not take the written value");

  a_irq_follows_latch: assert property (
    (CE_I && (|(latched & enable))) [*2] |=> IRQ_O)
    else $error("interrupt not raised for an enabled latched bit");

  a_irq_low_idle: assert property (
    CE_I && !(|(latched & enable)) |=> !IRQ_O)
    else $error("interrupt raised with no enabled latched bit");

  // Rule checks on the read path and on the latch; these catch a broken mux that the cell alone would hide.
  a_txe_live_read: assert property (
    s_read_status ##0 !enable[IDX_TX_EMPTY]
      |=> PRDATA_O[FLAG_LSB + IDX_TX_EMPTY] == $past(cond[IDX_TX_EMPTY]))
    else $error("disabled transmit empty bit did not read the live level");

  a_txf_latch_read: assert property (
    s_read_status ##0 (enable[IDX_TX_FULL] && latched[IDX_TX_FULL]) |=> PRDATA_O[FLAG_LSB + IDX_TX_FULL])
    else $error("captured transmit full event did not read as one");

  a_clear_drops_latch: assert property (
    s_clear_bit(IDX_TX_EMPTY) |=> !latched[IDX_TX_EMPTY])
    else $error("write one to clear left the latch set");

  a_set_wins_clear: assert property (
    CE_I && clear[IDX_RX_EMPTY] && enable[IDX_RX_EMPTY] && cond[IDX_RX_EMPTY] |=> latched[IDX_RX_EMPTY])
    else $error("event in the clear cycle was lost");

  a_disabled_no_latch: assert property (
    CE_I && !enable[IDX_TX_AFULL] && !latched[IDX_TX_AFULL] |=> !latched[IDX_TX_AFULL])
    else $error("disabled bit captured an event");

  // Bus answer checks; ready and error stand one cycle and read data only moves when a read is answered.
  sequence s_answer;
    CE_I && PSEL_I && !PREADY_O;
  endsequence

  a_ready_after_select: assert property (
    s_answer |=> PREADY_O)
    else $error("ready did not follow a select");

  a_ready_one_cycle: assert property (
    CE_I && PREADY_O |=> !PREADY_O)
    else $error("ready stood for more than one cycle");

  a_error_unmapped: assert property (
    s_answer ##0 (!hit_enable && !hit_status) |=> PSLVERR_O)
    else $error("unmapped address answered without an error");

  a_error_with_ready: assert property (
    PSLVERR_O |-> PREADY_O)
    else $error("error shown outside an answer");

  a_rdata_stands: assert property (
    !(CE_I && PSEL_I && !PREADY_O && !PWRITE_I) |=> $stable(PRDATA_O))
    else $error("read data moved outside a read answer");

  // A frozen block must not move its interrupt even while the flags change.
  a_ce_freeze_irq: assert property (
    !CE_I |=> $stable(IRQ_O))
    else $error("interrupt moved while the clock enable was low");

endmodule

/* fis_testbench.sv */
// Self-checking bench for the FIFO level flag interrupt status block.
// Assumes zero-wait APB answers on CLK_I and flags sampled at every edge.
`timescale 1ns/1ps
module testbench
  import fis_pkg::*;
();
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  fis_flags_t  flags;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        ce;
  logic [31:0] left;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;

  fis_irq_status u_dut (
    .CLK_I       (clk),
    .RST_N_I     (rst_n),
    .CE_I        (ce),
    .PSEL_I      (psel),
    .PENABLE_I   (penable),
    .PWRITE_I    (pwrite),
    .PADDR_I     (paddr),
    .PWDATA_I    (pwdata),
    .FIFO_FLAGS_I(flags),
    .PRDATA_O    (prdata),
    .PREADY_O    (pready),
    .PSLVERR_O   (pslverr),
    .IRQ_O       (irq)
  );

  // Free-running clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request is held until ready is seen at an edge, and any wait before it counts as a mismatch.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                      input logic e);
    logic [31:0] waits;
    waits = 32'h0000_0000;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Waits are counted, not capped; a ready that never comes is ended by the timeout.
    @(posedge clk);
    while (pready !== 1'b1) begin
      waits++;
      @(posedge clk);
    end
    chk("waits", 32'h0000_0000, waits);
    chk("slverr", {31'h0, e}, {31'h0, pslverr});
    if (!w) chk("rdata", exp, prdata);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Raises every flag for one edge only, then waits for the interrupt to settle.
  task automatic pulse();
    flags <= fis_flags_t'(6'h3F);
    @(posedge clk);
    flags <= '0;
    repeat (3) @(posedge clk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hung run short; the tests need under two hundred cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  // Main sequence of tests.
  initial begin
    rst_n   = 1'b0;
    ce      = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    flags   = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, OFS_ENABLE, '0, RST_WORD, 1'b0);
    xfer(1'b0, OFS_STATUS, '0, RST_WORD, 1'b0);
    $display("reset test done");
    for (int i = 0; i < FLAG_COUNT; i++) begin
      flags <= fis_flags_t'(6'h01 << i);
      xfer(1'b0, OFS_STATUS, '0, 32'h0000_0001 << (FLAG_LSB + i), 1'b0);
      chk("irq", 32'h0000_0000, {31'h0, irq});
    end
    flags <= '0;
    $display("live test done");
    xfer(1'b1, OFS_ENABLE, 32'h0000_3F00, '0, 1'b0);
    pulse();
    chk("irq", 32'h0000_0001, {31'h0, irq});
    xfer(1'b0, OFS_STATUS, '0, 32'h0000_3F00, 1'b0);
    left = 32'h0000_3F00;
    // Clears one bit at a time so that each must leave the others alone.
    for (int i = 0; i < FLAG_COUNT; i++) begin
      left[FLAG_LSB + i] = 1'b0;
      xfer(1'b1, OFS_STATUS, 32'h0000_0001 << (FLAG_LSB + i), '0, 1'b0);
      xfer(1'b0, OFS_STATUS, '0, left, 1'b0);
      chk("irq", {31'h0, |left}, {31'h0, irq});
    end
    $display("latch test done");
    xfer(1'b1, OFS_ENABLE, 32'hFFFF_FFFF, '0, 1'b0);
    xfer(1'b0, OFS_ENABLE, '0, 32'h0000_3F00, 1'b0);
    xfer(1'b1, OFS_ENABLE, 32'h0000_0100, '0, 1'b0);
    pulse();
    xfer(1'b0, OFS_STATUS, '0, 32'h0000_0100, 1'b0);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    xfer(1'b1, OFS_ENABLE, 32'h0000_0000, '0, 1'b0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    xfer(1'b1, 8'h38, 32'hFFFF_FFFF, '0, 1'b1);
    xfer(1'b0, 8'h38, '0, 32'h0000_0000, 1'b1);
    $display("mask and error test done");
    // With the clock enable low an enabled event must be ignored.
    xfer(1'b1, OFS_ENABLE, 32'h0000_0200, '0, 1'b0);
    ce <= 1'b0;
    pulse();
    ce <= 1'b1;
    xfer(1'b0, OFS_STATUS, '0, 32'h0000_0000, 1'b0);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    $display("freeze test done");
    // A flag still high when its clear lands sets the bit again; once low the clear sticks.
    flags <= fis_flags_t'(6'h10);
    xfer(1'b1, OFS_ENABLE, 32'h0000_1000, '0, 1'b0);
    xfer(1'b1, OFS_STATUS, 32'h0000_1000, '0, 1'b0);
    xfer(1'b0, OFS_STATUS, '0, 32'h0000_1000, 1'b0);
    flags <= '0;
    xfer(1'b1, OFS_STATUS, 32'h0000_1000, '0, 1'b0);
    xfer(1'b0, OFS_STATUS, '0, 32'h0000_0000, 1'b0);
    $display("set wins test done");
    give_verdict();
  end
endmodule
